// file: keypad_indicator.sv
// Front-panel keypad decoder and lamp driver for a motor drive.
// Assumes key inputs are synchronous, high while pressed, and that the
// motor control core supplies run, fault and displayed-quantity state.
//
// How it works
// - Ten keys, each conditioned and decoded to its own function.
// - Menu key enters primary menu; escape backs out; confirm saves.
// - Up/down step digit when editing, else step frequency reference.
// - Shift keys move digit when editing, else cycle displayed item.
// - Shift key during fault switches display to parameters.
// - Start key issues a run command.
// - Stop key issues stop, and fault reset while faulted.
// - Multifunction setting 0 ignores the multifunction key.
// - Setting 1 cycles command source keypad, terminal, comm.
// - Setting 2 jogs forward, setting 3 jogs reverse.
// - Setting 4 toggles commanded direction per press.
// - Source lamp on for keypad, off terminal, flashing comm.
// - Direction lamps while running; run lamp shows run state.
// - Unit lamps encode displayed quantity by combination.
// - Dimensionless quantity turns every unit lamp off.
// - Holding right shift three seconds opens changed-only menu.
// - With locking enabled, escape+up locks, escape+down unlocks.
`timescale 1ns/1ps
module keypad_indicator
  import keypad_pkg::*;
#(
  parameter int unsigned SETTLE     = DEBOUNCE_CYC,
  parameter int unsigned LONG_PRESS = LONG_PRESS_CYC,
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYC
) (
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  input  wire logic [9:0]      keyRaw,
  input  wire logic [2:0]      multifunctionKeySetting,
  input  wire logic            lockEnable,
  input  wire logic            driveRunning,
  input  wire logic            driveReverse,
  input  wire logic            faultActive,
  input  wire quantity_t       shownQuantity,
  output logic                 runCmd,
  output logic                 stopCmd,
  output logic                 faultResetCmd,
  output logic                 freqUp,
  output logic                 freqDown,
  output logic                 digitUp,
  output logic                 digitDown,
  output logic                 saveParam,
  output logic                 paramNext,
  output logic                 paramPrev,
  output logic                 jogFwd,
  output logic                 jogRev,
  output logic                 reverseDir,
  output cmd_src_t             cmdSource,
  output menu_t                menuState,
  output logic [DIGIT_W-1:0]   selDigit,
  output logic                 keysLocked,
  output logic                 commandSourceLamp,
  output logic                 runLamp,
  output logic                 forwardLamp,
  output logic                 reverseLamp,
  output logic                 hzLamp,
  output logic                 ampLamp,
  output logic                 voltLamp
);

  // ----------------------------------------------------------------
  // Key conditioning
  // ----------------------------------------------------------------
  logic [NUM_KEYS-1:0] lvl;
  logic [NUM_KEYS-1:0] prs;

  // One conditioner per key
  for (genvar i = 0; i < NUM_KEYS; i++) begin : g_key
    key_conditioner #(.SETTLE(SETTLE)) u_key (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .rawKey   (keyRaw[i]),
      .keyLevel (lvl[i]),
      .keyPress (prs[i])
    );
  end

  // ----------------------------------------------------------------
  // Key decode
  // ----------------------------------------------------------------
  logic  locked_q;
  logic  faultSeen_q;
  menu_t menu_q, menu_d;
  wire   escHeld  = lvl[K_ESC];
  // Lock chords checked even while locked, else unlock is unreachable
  wire   lockHit   = lockEnable & escHeld & prs[K_UP];
  wire   unlockHit = lockEnable & escHeld & prs[K_DOWN];
  wire   chord     = escHeld & (prs[K_UP] | prs[K_DOWN]);
  wire   live      = ~locked_q;
  wire   editing   = menu_q == MENU_EDIT;
  wire   inFault   = menu_q == MENU_FAULT;
  wire   pUp       = live & prs[K_UP] & ~chord;
  wire   pDown     = live & prs[K_DOWN] & ~chord;
  wire   pShift    = live & (prs[K_LEFT] | prs[K_RIGHT]);
  wire   pMulti    = live & prs[K_MULTI];

  // Stop stays live under lock: stopping the motor must never be blocked
  assign runCmd        = live & prs[K_START];
  assign stopCmd       = prs[K_STOP];
  assign faultResetCmd = prs[K_STOP] & faultActive;
  assign digitUp       = pUp & editing;
  assign digitDown     = pDown & editing;
  assign freqUp        = pUp & ~editing;
  assign freqDown      = pDown & ~editing;
  assign saveParam     = live & prs[K_OK] & editing;
  assign paramNext     = live & prs[K_RIGHT] & ~editing & ~inFault;
  assign paramPrev     = live & prs[K_LEFT] & ~editing & ~inFault;
  // Jog lasts as long as the key is held; setting 0 falls through
  assign jogFwd = live & lvl[K_MULTI]
                & (multifunctionKeySetting == MF_JOG_FWD);
  assign jogRev = live & lvl[K_MULTI]
                & (multifunctionKeySetting == MF_JOG_REV);

  // ----------------------------------------------------------------
  // Long press timer for right shift
  // ----------------------------------------------------------------
  localparam int LW = $clog2(LONG_PRESS + 1);
  logic [LW-1:0] hold_q;
  wire           holdDone = hold_q == LW'(LONG_PRESS - 1);

  // Counts while held and fires once; release re-arms it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= '0;
    end else if (!(lvl[K_RIGHT] && live)) begin
      hold_q <= '0;
    end else if (hold_q != LW'(LONG_PRESS)) begin
      hold_q <= hold_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Menu state
  // ----------------------------------------------------------------
  // Fault pre-empts any menu; shift keys leave the fault view
  always_comb begin
    menu_d = menu_q;
    case (menu_q)
      MENU_MONITOR: begin
        if (live && prs[K_MENU]) menu_d = MENU_PRIMARY;
      end
      MENU_PRIMARY: begin
        if (live && prs[K_OK]) menu_d = MENU_EDIT;
        else if (live && prs[K_ESC] && !chord) menu_d = MENU_MONITOR;
      end
      MENU_EDIT: begin
        if (saveParam) menu_d = MENU_PRIMARY;
        else if (live && prs[K_ESC] && !chord) menu_d = MENU_PRIMARY;
      end
      MENU_FAULT: begin
        if (pShift) menu_d = MENU_MONITOR;
        else if (faultResetCmd) menu_d = MENU_MONITOR;
      end
      MENU_CHANGED: begin
        if (live && prs[K_ESC] && !chord) menu_d = MENU_MONITOR;
        else if (live && prs[K_OK]) menu_d = MENU_EDIT;
      end
      default: menu_d = MENU_MONITOR;
    endcase
    if (holdDone && menu_q != MENU_FAULT) menu_d = MENU_CHANGED;
    if (faultActive && !faultSeen_q) menu_d = MENU_FAULT;
  end

  // Menu register; fault history makes fault entry edge-triggered
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      menu_q      <= MENU_MONITOR;
      faultSeen_q <= 1'b0;
    end else begin
      menu_q      <= menu_d;
      faultSeen_q <= faultActive;
    end
  end

  // ----------------------------------------------------------------
  // Digit select, lock, source and direction
  // ----------------------------------------------------------------
  logic [DIGIT_W-1:0] digit_q;
  cmd_src_t           src_q;
  logic               rev_q;
  wire                srcStep = pMulti
                              & (multifunctionKeySetting == MF_SOURCE);
  wire                dirStep = pMulti & (multifunctionKeySetting == MF_DIR);

  // Digit moves only while editing; left moves toward higher digits
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      digit_q <= '0;
    end else if (!editing) begin
      digit_q <= '0;
    end else if (live && prs[K_LEFT]) begin
      digit_q <= digit_q + 1'b1;
    end else if (live && prs[K_RIGHT]) begin
      digit_q <= digit_q - 1'b1;
    end
  end

  // Lock flag; dropping lock enable frees the keys at once
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      locked_q <= 1'b0;
    end else if (!lockEnable || unlockHit) begin
      locked_q <= 1'b0;
    end else if (lockHit) begin
      locked_q <= 1'b1;
    end
  end

  // Source cycles keypad, terminal, comm; direction toggles
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_q <= SRC_RESET;
      rev_q <= DIR_RESET;
    end else begin
      if (srcStep) begin
        case (src_q)
          SRC_KEYPAD:   src_q <= SRC_TERMINAL;
          SRC_TERMINAL: src_q <= SRC_COMM;
          default:      src_q <= SRC_KEYPAD;
        endcase
      end
      if (dirStep) rev_q <= ~rev_q;
    end
  end

  assign selDigit   = digit_q;
  assign cmdSource  = src_q;
  assign reverseDir = rev_q;
  assign keysLocked = locked_q;
  assign menuState  = menu_q;

  // ----------------------------------------------------------------
  // Lamps
  // ----------------------------------------------------------------
  localparam int FW = $clog2(FLASH_HALF + 1);
  logic [FW-1:0] pre_q;
  logic          flash_q;
  logic          srcLamp_q, runLamp_q, fwdLamp_q, revLamp_q;
  logic          hz_q, amp_q, volt_q;
  wire           preWrap = pre_q == FW'(FLASH_HALF - 1);

  // Prescaler sets a blink slow enough for the eye
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_q   <= '0;
      flash_q <= 1'b0;
    end else if (preWrap) begin
      pre_q   <= '0;
      flash_q <= ~flash_q;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Unit combinations; dimensionless leaves all dark
  wire uHz = shownQuantity inside {Q_FREQ, Q_SPEED, Q_POWER};
  wire uA  = shownQuantity inside {Q_CURRENT, Q_SPEED, Q_PERCENT};
  wire uV  = shownQuantity inside {Q_VOLTAGE, Q_PERCENT, Q_POWER};

  // All lamps registered so they never glitch
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      srcLamp_q <= 1'b0;
      runLamp_q <= 1'b0;
      fwdLamp_q <= 1'b0;
      revLamp_q <= 1'b0;
      hz_q      <= 1'b0;
      amp_q     <= 1'b0;
      volt_q    <= 1'b0;
    end else begin
      srcLamp_q <= (src_q == SRC_KEYPAD)
                 | ((src_q == SRC_COMM) & flash_q);
      runLamp_q <= driveRunning;
      fwdLamp_q <= driveRunning & ~driveReverse;
      revLamp_q <= driveRunning & driveReverse;
      hz_q      <= uHz;
      amp_q     <= uA;
      volt_q    <= uV;
    end
  end

  assign commandSourceLamp = srcLamp_q;
  assign runLamp           = runLamp_q;
  assign forwardLamp       = fwdLamp_q;
  assign reverseLamp       = revLamp_q;
  assign hzLamp            = hz_q;
  assign ampLamp           = amp_q;
  assign voltLamp          = volt_q;

endmodule

// file: keypad_pkg.sv
// Package for the drive front-panel keypad and indicator logic.
// Assumes a single 25 MHz controller clock shared by all users.
package keypad_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned DEBOUNCE_US     = 10_000;  // 10 ms settle
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LONG_PRESS_MS   = 3_000;   // 3 s hold
  localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_MS * (CLK_HZ / 1_000);
  localparam int unsigned FLASH_HALF_MS   = 250;     // 2 Hz blink
  localparam int unsigned FLASH_HALF_CYC  = FLASH_HALF_MS * (CLK_HZ / 1_000);

  // ----------------------------------------------------------------
  // Keys and settings
  // ----------------------------------------------------------------
  localparam int unsigned NUM_KEYS = 10;
  localparam int unsigned K_MENU   = 0;
  localparam int unsigned K_ESC    = 1;
  localparam int unsigned K_OK     = 2;
  localparam int unsigned K_UP     = 3;
  localparam int unsigned K_DOWN   = 4;
  localparam int unsigned K_LEFT   = 5;
  localparam int unsigned K_RIGHT  = 6;
  localparam int unsigned K_START  = 7;
  localparam int unsigned K_STOP   = 8;
  localparam int unsigned K_MULTI  = 9;

  localparam logic [2:0] MF_NONE    = 3'h0;
  localparam logic [2:0] MF_SOURCE  = 3'h1;
  localparam logic [2:0] MF_JOG_FWD = 3'h2;
  localparam logic [2:0] MF_JOG_REV = 3'h3;
  localparam logic [2:0] MF_DIR     = 3'h4;

  typedef enum logic [1:0] {
    SRC_KEYPAD, SRC_TERMINAL, SRC_COMM
  } cmd_src_t;

  typedef enum logic [2:0] {
    Q_FREQ, Q_CURRENT, Q_VOLTAGE, Q_SPEED, Q_PERCENT, Q_POWER, Q_NONE
  } quantity_t;

  typedef enum logic [2:0] {
    MENU_MONITOR, MENU_PRIMARY, MENU_EDIT, MENU_FAULT, MENU_CHANGED
  } menu_t;

  localparam cmd_src_t  SRC_RESET = SRC_KEYPAD;
  localparam logic      DIR_RESET = 1'b0;  // Forward
  localparam int unsigned DIGIT_W = 2;      // Four editable digits

endpackage

// file: key_conditioner.sv
// Debounce and rising-edge detector for one keypad key.
// Assumes the raw key level is synchronous to ref_clk, high while pressed.
`timescale 1ns/1ps
module key_conditioner
  import keypad_pkg::*;
#(
  parameter int unsigned SETTLE = DEBOUNCE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic rawKey,
  output logic      keyLevel,
  output logic      keyPress
);

  // ----------------------------------------------------------------
  // Settle counter
  // ----------------------------------------------------------------
  localparam int CW = $clog2(SETTLE + 1);
  logic [CW-1:0] cnt_q;
  logic          level_q;
  logic          prev_q;
  wire           differs = rawKey != level_q;
  wire           settled = cnt_q == CW'(SETTLE - 1);

  // Level only follows after the raw input differs for SETTLE cycles
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      prev_q <= level_q;
      if (!differs) begin
        cnt_q <= '0;
      end else if (settled) begin
        cnt_q   <= '0;
        level_q <= rawKey;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign keyLevel = level_q;
  assign keyPress = level_q & ~prev_q;  // One pulse per press

endmodule

// file: keypad_indicator_props.sv
// Port-level assertions for the keypad and lamp logic.
// Assumes one clock, ref_clk, and an async active-high sys_rst.
`timescale 1ns/1ps
module keypad_indicator_props
  import keypad_pkg::*;
#(
  parameter int unsigned SETTLE = 4
) (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic [9:0] keyRaw,
  input wire logic [2:0] multifunctionKeySetting,
  input wire logic       driveRunning,
  input wire logic       driveReverse,
  input wire quantity_t  shownQuantity,
  input wire logic       runCmd,
  input wire logic       stopCmd,
  input wire logic       faultResetCmd,
  input wire logic       jogFwd,
  input wire logic       jogRev,
  input wire logic       reverseDir,
  input wire cmd_src_t   cmdSource,
  input wire logic       commandSourceLamp,
  input wire logic       runLamp,
  input wire logic       forwardLamp,
  input wire logic       reverseLamp,
  input wire logic       hzLamp,
  input wire logic       ampLamp,
  input wire logic       voltLamp
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Lamps lag their cause by one edge; skip the edge right after reset
  a_run_lamp: assert property (
    !$past(sys_rst) |-> runLamp == $past(driveRunning))
    else $error("run lamp does not follow run state");
  a_dir_lamps: assert property (
    !$past(sys_rst) |->
      forwardLamp == ($past(driveRunning) && !$past(driveReverse)) &&
      reverseLamp == ($past(driveRunning) && $past(driveReverse)))
    else $error("direction lamps wrong");
  a_hz_unit: assert property (
    !$past(sys_rst) |->
      hzLamp == ($past(shownQuantity) inside {Q_FREQ, Q_SPEED, Q_POWER}))
    else $error("hz lamp wrong");
  a_amp_unit: assert property (
    !$past(sys_rst) |-> ampLamp ==
      ($past(shownQuantity) inside {Q_CURRENT, Q_SPEED, Q_PERCENT}))
    else $error("amp lamp wrong");
  a_volt_unit: assert property (
    !$past(sys_rst) |-> voltLamp ==
      ($past(shownQuantity) inside {Q_VOLTAGE, Q_PERCENT, Q_POWER}))
    else $error("volt lamp wrong");
  a_src_lamp: assert property (
    !$past(sys_rst) && $past(cmdSource) != SRC_COMM |->
      commandSourceLamp == ($past(cmdSource) == SRC_KEYPAD))
    else $error("source lamp wrong");
  a_dir_toggle: assert property (
    $changed(reverseDir) |-> $past(multifunctionKeySetting) == MF_DIR)
    else $error("direction changed without direction setting");
  a_src_cycle: assert property (
    $changed(cmdSource) |->
      $past(multifunctionKeySetting) == MF_SOURCE &&
      cmdSource == (($past(cmdSource) == SRC_COMM) ? SRC_KEYPAD :
        cmd_src_t'($past(cmdSource) + 2'h1)))
    else $error("source step out of order");
  a_jog_setting: assert property (
    (jogFwd |-> multifunctionKeySetting == MF_JOG_FWD) and
    (jogRev |-> multifunctionKeySetting == MF_JOG_REV))
    else $error("jog without matching setting");
  a_run_pulse: assert property (
    runCmd |-> $past(keyRaw[7], SETTLE) ##1 !runCmd)
    else $error("run pulse without held start key");
  a_fault_reset: assert property (
    faultResetCmd |-> stopCmd)
    else $error("fault reset without stop");
endmodule

bind keypad_indicator keypad_indicator_props #(.SETTLE(SETTLE)) props_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .keyRaw(keyRaw),
  .multifunctionKeySetting(multifunctionKeySetting),
  .driveRunning(driveRunning), .driveReverse(driveReverse),
  .shownQuantity(shownQuantity), .runCmd(runCmd), .stopCmd(stopCmd),
  .faultResetCmd(faultResetCmd), .jogFwd(jogFwd), .jogRev(jogRev),
  .reverseDir(reverseDir), .cmdSource(cmdSource),
  .commandSourceLamp(commandSourceLamp), .runLamp(runLamp),
  .forwardLamp(forwardLamp), .reverseLamp(reverseLamp),
  .hzLamp(hzLamp), .ampLamp(ampLamp), .voltLamp(voltLamp)
);

// file: key_operator.sv
// Operator model: presses, holds and releases keypad keys.
// Assumes the bench calls its tasks; levels change on rising edges.
`timescale 1ns/1ps
module key_operator (
  input  wire logic       ref_clk,
  output logic      [9:0] keyRaw
);
  initial keyRaw = 10'h000;

  // Single key actions, aligned to the rising edge
  task automatic press(input int k);
    @(posedge ref_clk);
    keyRaw[k] <= 1'b1;
  endtask
  task automatic lift(input int k);
    @(posedge ref_clk);
    keyRaw[k] <= 1'b0;
  endtask
  task automatic rest(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Release gap outlasts debounce so the next press is a new event
  task automatic tap(input int k, input int hold);
    press(k);
    rest(hold);
    lift(k);
    rest(12);
  endtask
  // Escape held first so the chord key sees it already settled
  task automatic chord(input int k);
    press(1);
    rest(8);
    tap(k, 10);
    lift(1);
    rest(12);
  endtask
endmodule

// file: keypad_indicator_tb.sv
// Self-checking bench for the keypad and lamp logic.
// Assumes short debounce, long-press and flash counts for run time.
`timescale 1ns/1ps
module keypad_indicator_tb;
  import keypad_pkg::*;
  logic            ref_clk;
  logic            sys_rst;
  logic [9:0]      keyRaw;
  logic [2:0]      mfSet;
  logic            lockEnable;
  logic            driveRunning;
  logic            driveReverse;
  logic            faultActive;
  quantity_t       shownQuantity;
  logic [9:0]      pv;
  logic            jogFwd;
  logic            jogRev;
  logic            reverseDir;
  cmd_src_t        cmdSource;
  menu_t           menuState;
  logic [1:0]      selDigit;
  logic            keysLocked;
  logic [6:0]      lamp;
  int              pc [10];
  int              err_total;
  int              checked;

  keypad_indicator #(.SETTLE(4), .LONG_PRESS(20), .FLASH_HALF(3))
    keypad_indicator_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .keyRaw(keyRaw),
    .multifunctionKeySetting(mfSet), .lockEnable(lockEnable),
    .driveRunning(driveRunning), .driveReverse(driveReverse),
    .faultActive(faultActive), .shownQuantity(shownQuantity),
    .runCmd(pv[0]), .stopCmd(pv[1]), .faultResetCmd(pv[2]),
    .freqUp(pv[3]), .freqDown(pv[4]), .digitUp(pv[5]),
    .digitDown(pv[6]), .saveParam(pv[7]), .paramNext(pv[8]),
    .paramPrev(pv[9]), .jogFwd(jogFwd), .jogRev(jogRev),
    .reverseDir(reverseDir), .cmdSource(cmdSource),
    .menuState(menuState), .selDigit(selDigit), .keysLocked(keysLocked),
    .commandSourceLamp(lamp[6]), .runLamp(lamp[5]),
    .forwardLamp(lamp[4]), .reverseLamp(lamp[3]),
    .hzLamp(lamp[2]), .ampLamp(lamp[1]), .voltLamp(lamp[0]));
  key_operator op_i (.ref_clk(ref_clk), .keyRaw(keyRaw));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Pulses are one cycle wide, so each edge counts at most one
  always @(posedge ref_clk) begin
    foreach (pc[i]) if (pv[i] === 1'b1) pc[i]++;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Clear on the falling edge, away from the counting edge
  task automatic clr();
    @(negedge ref_clk);
    foreach (pc[i]) pc[i] = 0;
  endtask
  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic wait_menu(input menu_t m);
    for (int i = 0; i < 100; i++) begin
      @(negedge ref_clk);
      if (menuState === m) begin
        checked++;
        return;
      end
    end
    err_total++;
    $display("wrong value menu expected %0d seen %0d", m, menuState);
    summarize();
  endtask
  task automatic only(input int k);
    foreach (pc[i]) check("pulse", pc[i], i == k);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_lamps();
    logic [2:0] ul [7] = '{3'h4, 3'h2, 3'h1, 3'h6, 3'h3, 3'h5, 3'h0};
    for (int q = 0; q < 7; q++) begin
      @(posedge ref_clk);
      shownQuantity <= quantity_t'(q);
      settle();
      check("units", lamp[2:0], ul[q]);
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge ref_clk);
      driveRunning <= r[1];
      driveReverse <= r[0];
      settle();
      check("run lamps", lamp[5:3],
            {r[1], r[1] & ~r[0], r[1] & r[0]});
    end
  endtask
  task automatic t_keys();
    int ks [6] = '{7, 8, 3, 4, 6, 5};
    int ps [6] = '{0, 1, 3, 4, 8, 9};
    for (int i = 0; i < 6; i++) begin
      clr();
      op_i.tap(ks[i], 15);
      only(ps[i]);
    end
    clr();
    op_i.tap(6, 10);
    check("shift", pc[8] + pc[9], 1);
  endtask
  task automatic t_menu();
    clr();
    op_i.tap(0, 10);
    wait_menu(MENU_PRIMARY);
    op_i.tap(2, 10);
    wait_menu(MENU_EDIT);
    op_i.tap(3, 10);
    op_i.tap(5, 10);
    check("digit", selDigit, 2'h1);
    check("digit up", pc[5], 1);
    check("freq in edit", pc[3], 0);
    op_i.tap(4, 10);
    check("digit down", pc[6], 1);
    op_i.tap(6, 10);
    check("digit back", selDigit, 2'h0);
    op_i.tap(2, 10);
    check("save", pc[7], 1);
    op_i.tap(1, 10);
    op_i.tap(1, 10);
    wait_menu(MENU_MONITOR);
  endtask
  task automatic t_fault();
    @(posedge ref_clk);
    faultActive <= 1'b1;
    wait_menu(MENU_FAULT);
    clr();
    op_i.tap(5, 10);
    check("fault view", menuState !== MENU_FAULT, 1);
    check("no shift", pc[8] + pc[9], 0);
    @(posedge ref_clk);
    faultActive <= 1'b0;
    @(posedge ref_clk);
    faultActive <= 1'b1;
    wait_menu(MENU_FAULT);
    clr();
    op_i.tap(8, 10);
    check("stop", pc[1], 1);
    check("fault reset", pc[2], 1);
    wait_menu(MENU_MONITOR);
    @(posedge ref_clk);
    faultActive <= 1'b0;
  endtask
  task automatic t_jog(input logic [2:0] s, input logic [1:0] e);
    @(posedge ref_clk);
    mfSet <= s;
    op_i.press(9);
    op_i.rest(8);
    settle();
    check("jog", {jogFwd, jogRev}, e);
    op_i.lift(9);
    op_i.rest(8);
    settle();
    check("jog end", {jogFwd, jogRev}, 2'h0);
  endtask
  task automatic t_multi();
    cmd_src_t se [3] = '{SRC_TERMINAL, SRC_COMM, SRC_KEYPAD};
    int tg;
    logic pl;
    t_jog(MF_NONE, 2'h0);
    check("source idle", cmdSource, SRC_KEYPAD);
    t_jog(MF_JOG_FWD, 2'h2);
    t_jog(MF_JOG_REV, 2'h1);
    @(posedge ref_clk);
    mfSet <= MF_SOURCE;
    for (int i = 0; i < 3; i++) begin
      op_i.tap(9, 10);
      check("source", cmdSource, se[i]);
      if (i == 0) check("lamp off", lamp[6], 1'b0);
    end
    op_i.tap(9, 10);
    op_i.tap(9, 10);
    tg = 0;
    @(negedge ref_clk);
    pl = lamp[6];
    for (int i = 0; i < 15; i++) begin
      @(negedge ref_clk);
      if (lamp[6] !== pl) tg++;
      pl = lamp[6];
    end
    // Half period of three cycles gives five toggles in fifteen steps
    check("flashing", tg >= 2, 1);
    check("flash rate", tg, 5);
    op_i.tap(9, 10);
    @(posedge ref_clk);
    mfSet <= MF_DIR;
    op_i.tap(9, 10);
    check("reverse", reverseDir, 1'b1);
    op_i.tap(9, 10);
    check("forward", reverseDir, 1'b0);
  endtask
  task automatic t_lock();
    op_i.press(6);
    wait_menu(MENU_CHANGED);
    op_i.lift(6);
    op_i.tap(1, 10);
    wait_menu(MENU_MONITOR);
    clr();
    op_i.chord(3);
    check("lock off", keysLocked, 1'b0);
    check("chord freq", pc[3], 0);
    @(posedge ref_clk);
    lockEnable <= 1'b1;
    clr();
    op_i.chord(3);
    check("locked", keysLocked, 1'b1);
    op_i.tap(7, 10);
    check("locked keys", pc[0] + pc[3], 0);
    op_i.chord(4);
    check("unlocked", keysLocked, 1'b0);
    op_i.chord(3);
    check("relocked", keysLocked, 1'b1);
    @(posedge ref_clk);
    lockEnable <= 1'b0;
    settle();
    check("enable drop", keysLocked, 1'b0);
  endtask

  initial begin
    err_total = 0;
    checked = 0;
    sys_rst = 1'b1;
    mfSet = MF_NONE;
    lockEnable = 1'b0;
    driveRunning = 1'b0;
    driveReverse = 1'b0;
    faultActive = 1'b0;
    shownQuantity = Q_FREQ;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle();
    check("reset source", cmdSource, SRC_KEYPAD);
    check("reset lamp", lamp[6], 1'b1);
    t_lamps();
    t_keys();
    t_menu();
    t_fault();
    t_multi();
    t_lock();
    summarize();
  end
endmodule
